/* File: design/sas_pkg.sv */
package sas_pkg;

    // ****************************************
    // time base
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int OSC_PERIOD_US = 10500;
    localparam int EMIT_WIDTH_US = 105;
    localparam int OSC_DIV_CYC = OSC_PERIOD_US * CLK_MHZ;
    localparam int EMIT_CYC = EMIT_WIDTH_US * CLK_MHZ;

    // ****************************************
    // pulse periods, in oscillator cycles
    // ****************************************
    localparam logic [9:0] PER_IDLE = 10'h3FF;   // 1024 - 1
    localparam logic [9:0] PER_ONE = 10'h0BF;    // 192 - 1
    localparam logic [9:0] PER_TWO = 10'h05F;    // 96 - 1
    localparam logic [9:0] PER_REMOTE = 10'h2FF; // 768 - 1
    localparam logic [9:0] PER_TEST = 10'h017;   // 24 - 1
    localparam logic [11:0] LED_ALARM = 12'h02F; // 48 - 1
    localparam logic [11:0] LED_HUSH = 12'h3FF;  // 1024 - 1
    localparam logic [11:0] LED_BLINK = 12'hFFF; // 4096 - 1

    // ****************************************
    // sequence lengths
    // ****************************************
    localparam logic [1:0] SMOKE_NEEDED = 2'h3;
    localparam logic [3:0] IO_QUAL = 4'h9;
    localparam logic [6:0] DUMP_LEN = 7'h60;       // 96
    localparam logic [15:0] HUSH_LEN = 16'hE000;   // 57344
    localparam logic [11:0] FAIL_HOLD = 12'hA00;   // 2560, inside 2048..3072
    localparam logic [8:0] HORN_CYCLE = 9'h17F;    // 384 - 1
    localparam logic [8:0] HORN_ON = 9'h030;       // 48
    localparam logic [8:0] HORN_LONG_OFF = 9'h0F0; // three on phases with two off phases between
    localparam logic [11:0] CHIRP_GAP = 12'h040;   // 2^6

    // ****************************************
    // sound IC codes
    // ****************************************
    localparam logic [2:0] CODE_STANDBY = 3'h0;
    localparam logic [2:0] CODE_LOCAL = 3'h1;
    localparam logic [2:0] CODE_REMOTE = 3'h2;
    localparam logic [2:0] CODE_PASS = 3'h3;
    localparam logic [2:0] CODE_FAIL = 3'h4;
    localparam logic [2:0] CODE_LOWBAT = 3'h5;
    localparam logic [2:0] CODE_CHAMBER = 3'h6;

    // input bit positions at the synchroniser
    localparam int IN_TEST = 0;
    localparam int IN_IO = 1;
    localparam int IN_SMOKE = 2;
    localparam int IN_LOWBAT = 3;
    localparam int IN_CHAMBER = 4;
    localparam int IN_HUSH = 5;
    localparam int IN_BLINK = 6;
    localparam int IN_COUNT = 7;

endpackage

/* File: design/sas_sync2.sv */
`timescale 1ns/1ps
module sas_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    // first stage feeds only the second stage
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule

/* File: design/sas_sequencer.sv */
`timescale 1ns/1ps
// Contract
// - idle: strobe and emitter pulse every 1024 oscillator cycles
// - one valid smoke sample: pulse period 192 cycles
// - two samples or local alarm: pulse period 96 cycles
// - outside local alarm: high-gain chamber check every 2^18 cycles
// - push test active: pulse every 24 cycles
// - local alarm after three consecutive detections; raises hysteresis gain
// - high gain in test and chamber check, low gain in standby
// - local smoke drives interconnect high
// - standby samples interconnect every 4 cycles, needs sustained high
// - any low during qualification cancels; short pulses rejected
// - remote alarm 9 to 13 cycles after interconnect rises
// - local alarm stops interconnect being an input
// - indicator pulses suppressed during remote alarm; only the blink is masked, test and quiet-timer pulses still show
// - end of local or test alarm: discharge for 96 cycles
// - three push-pull code outputs with fixed state codes
// - supply or chamber warning: code pulse 1 cycle per 2^12
// - battery warning: horn 1 cycle per 2^12; chamber warning: horn 3 cycles per 2^12
// - chamber warning is three chirps 2^6 cycles apart
// - alarms drive temporal horn pattern 48 on 48 off, 144 off
// - failed test code held 2^11..3072 cycles after release
// - emitter never on while indicator is on
// - quiet timer restarted by button release, lasts 57344 cycles
// - horn output high enables the boost converter
module sas_sequencer #(
    parameter int OSC_DIV = sas_pkg::OSC_DIV_CYC,
    parameter int EMIT_LEN = sas_pkg::EMIT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic testButton,
    input wire logic ioIn,
    input wire logic smokeDetect,
    input wire logic lowBattery,
    input wire logic chamberDegraded,
    input wire logic hushEnable,
    input wire logic blinkEnable,
    output logic strobe,
    output logic emitter,
    output logic indicator,
    output logic high_gain_cap,
    output logic low_gain_cap,
    output logic hysteresisRaise,
    output logic quietMode,
    output logic ioOut,
    output logic ioOe,
    output logic ioDump,
    output logic sound_code_bit0,
    output logic sound_code_bit1,
    output logic sound_code_bit2,
    output logic horn
);
    import sas_pkg::*;

    // ****************************************
    // input synchronisers and time base
    // ****************************************
    logic [IN_COUNT-1:0] pinsSync;
    logic [18:0] divCount;
    logic [17:0] oscCount;
    logic oscTick;
    logic sTest, sIo, sSmoke, sLowBat, sChamber, sHush, sBlink;

    sas_sync2 #(.WIDTH(IN_COUNT)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async({blinkEnable, hushEnable, chamberDegraded, lowBattery,
                smokeDetect, ioIn, testButton}),
        .synced(pinsSync)
    );

    assign sTest = pinsSync[IN_TEST];
    assign sIo = pinsSync[IN_IO];
    assign sSmoke = pinsSync[IN_SMOKE];
    assign sLowBat = pinsSync[IN_LOWBAT];
    assign sChamber = pinsSync[IN_CHAMBER];
    assign sHush = pinsSync[IN_HUSH];
    assign sBlink = pinsSync[IN_BLINK];
    assign oscTick = (divCount == 19'(OSC_DIV - 1));

    // one oscillator cycle is the unit of every timer below
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCount <= '0;
            oscCount <= '0;
        end else begin
            divCount <= oscTick ? '0 : divCount + 19'h1;
            if (oscTick) begin
                oscCount <= oscCount + 18'h1;
            end
        end
    end

    // ****************************************
    // smoke sampling and test state
    // ****************************************
    logic [1:0] smokeCnt, testHits, testMiss;
    logic localAlarm, testPass, testFail, testPrev, chkCycle;
    logic remoteAlarm;
    logic [9:0] perCount;
    logic sampleDone, fire, chamberTick, testFall, alarmAfter;
    logic [1:0] cntAfter;

    function automatic logic [9:0] periodFor(input logic test,
            input logic alarm, input logic [1:0] cnt, input logic remote);
        logic [9:0] p;
        p = PER_IDLE;
        if (test) p = PER_TEST;
        else if (alarm || cnt == 2'h2) p = PER_TWO;
        else if (cnt == 2'h1) p = PER_ONE;
        else if (remote) p = PER_REMOTE;
        return p;
    endfunction

    assign sampleDone = oscTick && strobe && !chkCycle;
    assign chamberTick = oscTick && oscCount == '0 && !localAlarm;
    assign fire = oscTick && perCount == '0;
    assign testFall = testPrev && !sTest;
    assign cntAfter = sSmoke ? smokeCnt + {1'b0, smokeCnt != 2'h3} : 2'h0;
    assign alarmAfter = sSmoke && smokeCnt >= 2'h2;

    // ordinary samples count toward alarm; test samples toward pass/fail
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            smokeCnt <= '0;
            localAlarm <= 1'b0;
            testHits <= '0;
            testMiss <= '0;
        end else if (sampleDone && sTest) begin
            testHits <= sSmoke ? testHits + {1'b0, testHits != 2'h3} : '0;
            testMiss <= sSmoke ? '0 : testMiss + {1'b0, testMiss != 2'h3};
        end else if (sampleDone) begin
            smokeCnt <= cntAfter;
            localAlarm <= alarmAfter;
        end else if (!sTest) begin
            testHits <= '0;
            testMiss <= '0;
        end
    end

    // pass or fail holds for the button press; the period reloads at
    // each sample end outside test so a faster rate takes hold at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            testPass <= 1'b0;
            testFail <= 1'b0;
            testPrev <= 1'b0;
            perCount <= PER_IDLE;
            strobe <= 1'b0;
            chkCycle <= 1'b0;
        end else begin
            testPrev <= sTest;
            testPass <= sTest && (testPass || testHits == SMOKE_NEEDED);
            testFail <= sTest && (testFail || testMiss == SMOKE_NEEDED);
            if (sTest && !testPrev) begin
                perCount <= PER_TEST;
            end else if (sampleDone && !sTest) begin
                perCount <= periodFor(1'b0, alarmAfter, cntAfter,
                                      remoteAlarm) - 10'h1;
            end else if (oscTick) begin
                perCount <= fire ? periodFor(sTest, localAlarm, smokeCnt,
                                             remoteAlarm) : perCount - 10'h1;
            end
            if (oscTick) begin
                strobe <= fire || chamberTick;
                chkCycle <= chamberTick && !fire;
            end
        end
    end

    // ****************************************
    // interconnect qualification and drive
    // ****************************************
    logic [3:0] ioRun;
    logic [6:0] dumpCnt;
    logic alarmDrive, drivePrev;
    logic [11:0] failCnt;
    logic [15:0] quietCnt;

    assign alarmDrive = localAlarm || testPass;

    // any low clock sample clears the run, so short pulses die here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ioRun <= '0;
            remoteAlarm <= 1'b0;
        end else if (alarmDrive || !sIo) begin
            ioRun <= '0;
            remoteAlarm <= 1'b0;
        end else if (oscTick) begin
            ioRun <= (ioRun == IO_QUAL) ? ioRun : ioRun + 4'h1;
            if (oscCount[1:0] == 2'h0 && ioRun == IO_QUAL) begin
                remoteAlarm <= 1'b1;
            end
        end
    end

    // discharge, failed-test hold and quiet timer all count osc cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drivePrev <= 1'b0;
            dumpCnt <= '0;
            failCnt <= '0;
            quietCnt <= '0;
        end else begin
            drivePrev <= alarmDrive;
            if (drivePrev && !alarmDrive) begin
                dumpCnt <= DUMP_LEN;
            end else if (oscTick && dumpCnt != '0) begin
                dumpCnt <= dumpCnt - 7'h1;
            end
            if (testFall && testFail) begin
                failCnt <= FAIL_HOLD;
            end else if (oscTick && failCnt != '0) begin
                failCnt <= failCnt - 12'h1;
            end
            if (testFall && sHush) begin
                quietCnt <= HUSH_LEN;
            end else if (oscTick && quietCnt != '0) begin
                quietCnt <= quietCnt - 16'h1;
            end
        end
    end

    // ****************************************
    // indicator, emitter and gain selection
    // ****************************************
    logic [11:0] ledCount, ledPeriod;
    logic ledAllowed, ledFire, next_emitter, next_indicator;
    logic warnSlot, chirpSlot;

    assign ledPeriod = (localAlarm || sTest) ? LED_ALARM :
                       (quietCnt != '0) ? LED_HUSH : LED_BLINK;
    assign ledAllowed = localAlarm || sTest || quietCnt != '0 ||
                        (sBlink && !remoteAlarm);
    assign ledFire = oscTick && ledCount == '0 && ledAllowed;
    assign next_indicator = oscTick ? ledFire : indicator;
    // emitter sits at the tail of the strobe window, never beside the led
    assign next_emitter = strobe && !next_indicator &&
                          divCount >= 19'(OSC_DIV - EMIT_LEN);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ledCount <= LED_BLINK;
            indicator <= 1'b0;
            emitter <= 1'b0;
            high_gain_cap <= 1'b0;
            low_gain_cap <= 1'b1;
            hysteresisRaise <= 1'b0;
            quietMode <= 1'b0;
        end else begin
            if (oscTick) begin
                ledCount <= (ledCount == '0 || ledCount > ledPeriod) ?
                            ledPeriod : ledCount - 12'h1;
            end
            indicator <= next_indicator;
            emitter <= next_emitter;
            high_gain_cap <= sTest || chkCycle;
            low_gain_cap <= !(sTest || chkCycle);
            hysteresisRaise <= localAlarm;
            quietMode <= quietCnt != '0;
        end
    end

    // ****************************************
    // sound code, horn and interconnect outputs
    // ****************************************
    logic [8:0] hornPhase;
    logic [2:0] soundCode, next_code;
    logic warnPulse, chirp, alarmSound, patternOn, next_horn;

    assign warnSlot = oscCount[11:0] == '0;
    assign chirpSlot = warnSlot || oscCount[11:0] == CHIRP_GAP ||
                       oscCount[11:0] == 12'(CHIRP_GAP << 1);
    assign alarmSound = localAlarm || remoteAlarm || testPass;
    assign patternOn = hornPhase < HORN_LONG_OFF &&
                       (hornPhase % (HORN_ON << 1)) < HORN_ON;
    assign next_horn = alarmSound ? patternOn : chirp;
    assign next_code = localAlarm ? CODE_LOCAL :
                       testPass ? CODE_PASS :
                       (testFail || failCnt != '0) ? CODE_FAIL :
                       remoteAlarm ? CODE_REMOTE :
                       (warnPulse && sLowBat) ? CODE_LOWBAT :
                       (warnPulse && sChamber) ? CODE_CHAMBER :
                       CODE_STANDBY;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hornPhase <= '0;
            warnPulse <= 1'b0;
            chirp <= 1'b0;
            soundCode <= CODE_STANDBY;
            horn <= 1'b0;
            ioOut <= 1'b0;
            ioOe <= 1'b0;
            ioDump <= 1'b0;
        end else begin
            if (!alarmSound) begin
                hornPhase <= '0;
            end else if (oscTick) begin
                hornPhase <= (hornPhase == HORN_CYCLE) ? '0 :
                             hornPhase + 9'h1;
            end
            if (oscTick) begin
                warnPulse <= warnSlot && (sLowBat || sChamber);
                chirp <= (sLowBat && warnSlot) ||
                         (sChamber && chirpSlot);
            end
            soundCode <= next_code;
            horn <= next_horn;
            ioOut <= alarmDrive;
            ioOe <= alarmDrive;
            ioDump <= dumpCnt != '0;
        end
    end

    assign sound_code_bit0 = soundCode[0];
    assign sound_code_bit1 = soundCode[1];
    assign sound_code_bit2 = soundCode[2];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    led_emit_excl_a: assert property (!(emitter && indicator))
        else $error("emitter on while indicator on");
    io_drive_a: assert property (localAlarm |=> ioOut && ioOe)
        else $error("interconnect not driven in local alarm");
    local_code_a: assert property (localAlarm |=>
            soundCode == CODE_LOCAL)
        else $error("wrong code during local alarm");
    three_hits_a: assert property ($rose(localAlarm) |->
            $past(smokeCnt) == 2'h2 && smokeCnt == 2'h3)
        else $error("local alarm without three detections");
    hyst_gain_a: assert property ($rose(localAlarm) |=>
            hysteresisRaise)
        else $error("hysteresis not raised");
    io_ignored_a: assert property (localAlarm |=> !remoteAlarm)
        else $error("interconnect read during local alarm");
    dump_start_a: assert property ($fell(alarmDrive) |-> ##[1:2] ioDump)
        else $error("discharge missing after alarm");
    test_gain_a: assert property (sTest |=> high_gain_cap &&
            !low_gain_cap)
        else $error("high gain not selected in test");
    remote_led_a: assert property ((remoteAlarm && !localAlarm && !sTest &&
            quietCnt == '0) [*2] |-> !indicator)
        else $error("indicator pulse during remote alarm");
    short_io_a: assert property ($rose(remoteAlarm) |->
            $past(sIo, 1) && ioRun >= IO_QUAL - 4'h1)
        else $error("remote alarm without qualified high");
endmodule

/* File: test/sas_far_side.sv */
`timescale 1ns/1ps
// ****************************************
// interconnect line as the other detectors see it
// ****************************************
module sas_far_side (
    input wire logic remoteDrive,
    input wire logic ioOut,
    input wire logic ioOe,
    input wire logic ioDump,
    output logic ioLine
);
    // the line has a pull-down, so once released it reads low, never
    // the last value; the dump device only wins when nobody drives high
    assign ioLine = (ioOe & ioOut) | (remoteDrive & ~(ioDump & ~remoteDrive));
endmodule

/* File: test/sas_sequencer_tb.sv */
`timescale 1ns/1ps
module sas_sequencer_tb;
    import sas_pkg::*;
    localparam int OSC = 40;
    logic clk, arst_n, testButton, smokeDetect, lowBattery, chamberDegraded;
    logic hushEnable, blinkEnable, remoteDrive, ioLine;
    logic strobe, emitter, indicator, highGain, lowGain, hystRaise, quietMode;
    logic ioOut, ioOe, ioDump, sc0, sc1, sc2, horn;
    logic [2:0] code;
    int n_errors, compares, cyc, nStrobe;
    realtime tStrobe, tPrev;

    assign code = {sc2, sc1, sc0};

    sas_sequencer #(.OSC_DIV(OSC), .EMIT_LEN(4)) dut (
        .clk(clk), .arst_n(arst_n), .testButton(testButton), .ioIn(ioLine),
        .smokeDetect(smokeDetect), .lowBattery(lowBattery),
        .chamberDegraded(chamberDegraded), .hushEnable(hushEnable),
        .blinkEnable(blinkEnable), .strobe(strobe), .emitter(emitter),
        .indicator(indicator), .high_gain_cap(highGain),
        .low_gain_cap(lowGain), .hysteresisRaise(hystRaise),
        .quietMode(quietMode), .ioOut(ioOut), .ioOe(ioOe), .ioDump(ioDump),
        .sound_code_bit0(sc0), .sound_code_bit1(sc1), .sound_code_bit2(sc2),
        .horn(horn)
    );

    sas_far_side far (
        .remoteDrive(remoteDrive), .ioOut(ioOut), .ioOe(ioOe),
        .ioDump(ioDump), .ioLine(ioLine)
    );

    // ****************************************
    // clock, run limit, strobe timestamps
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ceiling sits above the longest expected run of all scenarios
    always @(posedge clk) begin
        cyc++;
        if (cyc == 98000) begin
            n_errors++;
            $display("[FAIL] %0t run limit reached", $time);
            finish_test();
        end
    end

    always @(posedge strobe) begin
        tPrev = tStrobe;
        tStrobe = $realtime;
        nStrobe++;
    end

    // continuous watch of output relations, sampled on the quiet edge
    always @(negedge clk) begin
        if (arst_n === 1'b1) begin
            check(!(emitter === 1'b1 && indicator === 1'b1), "ired with led");
            check(code !== 3'h7, "unused sound code");
        end
    end

    // ****************************************
    // shared helpers
    // ****************************************
    task check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task at_edge();
        @(posedge clk);
        #1;
    endtask

    function logic [2:0] probe(input int which);
        case (which)
            0: probe = code;
            1: probe = {2'h0, horn};
            default: probe = {2'h0, ioDump};
        endcase
    endfunction

    task wait_val(input int which, input logic [2:0] val, input int lim,
                  output int n);
        n = 0;
        while (probe(which) !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (probe(which) !== val) check(1'b0, "wait limit reached");
    endtask

    task high_len(input int which, input int lim, output int len);
        int n;
        wait_val(which, 3'h1, lim, n);
        wait_val(which, 3'h0, lim, len);
    endtask

    task next_strobe(input int lim, output int gap);
        int n0;
        int n;
        n0 = nStrobe;
        n = 0;
        while (nStrobe == n0 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (nStrobe == n0) check(1'b0, "no strobe seen");
        gap = int'((tStrobe - tPrev) / 25.0);
    endtask

    task finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // a short pulse, a gap, then a held line from another unit
    task test_remote();
        int n;
        int m;
        at_edge();
        remoteDrive = 1'b1;
        repeat (6 * OSC) at_edge();
        remoteDrive = 1'b0;
        repeat (3) at_edge();
        remoteDrive = 1'b1;
        check(code === CODE_STANDBY, "short pulse accepted");
        wait_val(0, CODE_REMOTE, 14 * OSC, n);
        check(n >= 9 * OSC && n <= 13 * OSC + 3, "remote delay");
        m = 0;
        repeat (20 * OSC) begin
            @(negedge clk);
            if (indicator === 1'b1 || ioDump === 1'b1) m++;
        end
        check(m == 0, "led or dump in remote alarm");
        check(horn === 1'b1, "horn off in remote alarm");
        at_edge();
        remoteDrive = 1'b0;
        wait_val(0, CODE_STANDBY, 4 * OSC, n);
        $display("test remote done");
    endtask

    // push test with reflections present, quiet timer disabled
    task test_pass();
        int g;
        int n;
        int len;
        hushEnable = 1'b0;
        at_edge();
        testButton = 1'b1;
        smokeDetect = 1'b1;
        next_strobe(30 * OSC, g);
        next_strobe(30 * OSC, g);
        check(g == 24 * OSC, "test strobe period");
        check(highGain === 1'b1 && lowGain === 1'b0, "gain in test");
        wait_val(0, CODE_PASS, 100 * OSC, n);
        repeat (2) @(negedge clk);
        check(ioOe === 1'b1 && ioOut === 1'b1, "line not driven");
        at_edge();
        testButton = 1'b0;
        smokeDetect = 1'b0;
        wait_val(0, CODE_STANDBY, 4 * OSC, n);
        high_len(2, 100 * OSC, len);
        check(len >= 95 * OSC && len <= 96 * OSC + 2, "dump length");
        check(lowGain === 1'b1 && highGain === 1'b0, "gain after test");
        check(quietMode === 1'b0, "quiet timer while disabled");
        $display("test pass done");
    endtask

    // three-stage speedup into a local alarm and back out
    task test_smoke();
        int g;
        int n;
        int len;
        at_edge();
        smokeDetect = 1'b1;
        next_strobe(1100 * OSC, g);
        next_strobe(200 * OSC, g);
        check(g == 192 * OSC, "period after one sample");
        next_strobe(100 * OSC, g);
        check(g == 96 * OSC, "period after two samples");
        wait_val(0, CODE_LOCAL, 100 * OSC, n);
        @(negedge clk);
        check(hystRaise === 1'b1, "hysteresis not raised");
        check(ioOe === 1'b1 && ioOut === 1'b1, "line not driven");
        high_len(1, 60 * OSC, len);
        check(len >= 47 * OSC && len <= 48 * OSC + 2, "horn on time");
        wait_val(1, 3'h1, 60 * OSC, n);
        check(n >= 47 * OSC && n <= 48 * OSC + 2, "horn off time");
        next_strobe(100 * OSC, g);
        next_strobe(100 * OSC, g);
        check(g == 96 * OSC, "period in alarm");
        check(code === CODE_LOCAL, "line read back as remote");
        at_edge();
        smokeDetect = 1'b0;
        wait_val(0, CODE_STANDBY, 100 * OSC, n);
        high_len(2, 100 * OSC, len);
        check(len >= 95 * OSC && len <= 96 * OSC + 2, "dump length");
        check(horn === 1'b0, "horn after alarm");
        $display("test smoke done");
    endtask

    // push test on a blind chamber, quiet timer enabled
    task test_fail();
        int n;
        hushEnable = 1'b1;
        at_edge();
        testButton = 1'b1;
        smokeDetect = 1'b0;
        wait_val(0, CODE_FAIL, 100 * OSC, n);
        check(ioOe === 1'b0 && horn === 1'b0, "failed test drives out");
        at_edge();
        testButton = 1'b0;
        repeat (5) @(negedge clk);
        check(quietMode === 1'b1, "quiet timer not started");
        repeat (100 * OSC) @(negedge clk);
        check(code === CODE_FAIL, "fail code dropped early");
        $display("test fail done");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        testButton = 1'b0;
        smokeDetect = 1'b0;
        lowBattery = 1'b0;
        chamberDegraded = 1'b0;
        hushEnable = 1'b0;
        blinkEnable = 1'b0;
        remoteDrive = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        arst_n = 1'b1;
        test_remote();
        test_pass();
        test_smoke();
        test_fail();
        finish_test();
    end
endmodule
